// >>> design/scan_timing_cfg.svh
// register map, field positions, reset values and timing constants
`ifndef SCAN_TIMING_CFG_SVH
`define SCAN_TIMING_CFG_SVH

// ********************************
// register offsets
// ********************************
`define OFF_CONTROL        12'h000
`define OFF_STATUS         12'h004
`define OFF_LINE_RECORD    12'h008
`define OFF_OPEN_LOW       12'h00C
`define OFF_OPEN_HIGH      12'h010
`define OFF_GHOST_LINES    12'h014

// ********************************
// control field positions
// ********************************
`define CTL_RANGE_LSB      0
`define CTL_MULT_LSB       2
`define CTL_LSWT_LSB       6
`define CTL_READBACK_BIT   10
`define CTL_GHOST_BIT      11
`define CTL_RED_LSB        12
`define CTL_GREEN_LSB      16
`define CTL_BLUE_LSB       20

// ********************************
// reset values
// ********************************
`define RST_RANGE          2'h0
`define RST_MULT           4'h3
`define RST_LSWT           4'h0
`define RST_THRESH         4'h8

// ********************************
// clock range limits and line switch timing, in MHz and grayscale clocks, and the ghost slot count
// ********************************
`define GS_MIN_MHZ         40
`define GS_MAX_MHZ         160
`define GS_HALF_LIMIT_MHZ  80
`define LSWT_BASE_CLKS     45
`define LSWT_STEP_CLKS     30
`define GHOST_SLOTS        3

`endif

// >>> design/scan_timing_pkg.sv
// types shared by the scan timing and open fault unit
package scan_timing_pkg;
	typedef enum logic [2:0] {PWM_RUN, GAP_T0, GAP_T1, GAP_T2, GAP_T3} phase_type;

	typedef struct packed {
		logic        used;
		logic [3:0]  line;
		logic [47:0] mask;
	} ghost_slot_type;

	typedef struct packed {
		logic [1:0]     range_sel;
		logic [3:0]     mult;
		logic [3:0]     lswt;
		logic           readback_en;
		logic           ghost_en;
		logic [3:0]     thr_red;
		logic [3:0]     thr_green;
		logic [3:0]     thr_blue;
		phase_type      phase;
		logic [9:0]     count;
		logic [3:0]     line;
		logic [47:0]    seg_open;
		logic [47:0]    open_data;
		logic [15:0]    line_record;
		ghost_slot_type [2:0] slots;
		logic [4:0]     sync1;
		logic [4:0]     sync2;
		logic [47:0]    cmp1;
		logic [47:0]    cmp2;
		logic           hot_off;
		logic           ref_off;
		logic [47:0]    chan_on;
		logic [15:0]    line_on;
		logic           pre_dis;
		logic [31:0]    rdata;
		logic           slverr;
		logic [47:0]    on_seen1;
		logic [47:0]    on_seen2;
		logic           half_div;
		logic           pwm_on;
	} unit_state_type;
endpackage

// >>> design/scan_timing_open_fault_unit.sv
// scan line timing, thermal and reference protection, open LED detection and removal
//
// Summary of operation
// (RL1) grayscale clock setting comes from range and multiplier fields, 40 to 160 MHz
// (RL2) at or below 80 MHz the half divider select is 1
// (RL3) above 80 MHz the half divider select is 0
// (RL4) transition starts with T0 then T1 before the current line turns off
// (RL5) T2 runs from current line off until next line on
// (RL6) T3 runs until next PWM; four intervals sum to the transition time
// (RL7) a four-bit line switch time code sets the total transition time
// (RL8) code 0 gives 45 clocks, code 1 gives 60, each step after code 1 adds 30
// (RL9) outputs off above 170 C, back on once below 155 C
// (RL10) outputs off while reference pin low, back on only once it reads high
// (RL11) per channel open flag is 1 when output exceeds its colour threshold
// (RL12) open comparator results count only while that channel is switched on
// (RL13) lines with open LEDs are recorded; flags latch at each segment end
// (RL14) host enables fault readback before reading open LED data
// (RL15) host waits one sub-period between second and third readback commands
// (RL16) with ghost removal on, open channels stay off on their recorded line
// (RL17) suppression lasts until reset or ghost removal is turned off
// (RL18) only the first three faulty lines are suppressed
// (RL19) entering initialization resets all configuration registers
// (RL20) suppressed positions kept as line and channel mask pairs, cleared on reset
//
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "scan_timing_cfg.svh"

module scan_timing_open_fault_unit #(
	parameter int SCLK_MHZ      = 20,
	parameter int SEG_PWM_CLKS  = 256,
	parameter int LINES         = 16
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic      [31:0] prdata,
	output logic             pslverr,
	input  wire logic        temp_above_hot,
	input  wire logic        temp_below_cool,
	input  wire logic        ref_pin_low,
	input  wire logic        ref_pin_high,
	input  wire logic        init_request,
	input  wire logic [47:0] open_load_detect,
	output logic       [1:0] clock_range_select,
	output logic       [3:0] clock_multiply_factor,
	output logic             half_divider_select,
	output logic       [3:0] red_open_threshold,
	output logic       [3:0] green_open_threshold,
	output logic       [3:0] blue_open_threshold,
	output logic      [47:0] channel_output,
	output logic      [15:0] line_enable,
	output logic             pre_discharge,
	output logic             pwm_window
);
	import scan_timing_pkg::*;

	// half divider state after reset follows the reset range and multiplier
	localparam int   RST_MHZ  = (SCLK_MHZ * (int'(`RST_MULT) + 1)) >> int'(`RST_RANGE);
	localparam logic RST_HALF = (RST_MHZ <= `GS_HALF_LIMIT_MHZ) ? 1'b1 : 1'b0;

	// ********************************
	// helpers
	// ********************************
	function automatic logic [7:0] gs_mhz(input logic [1:0] rs, input logic [3:0] m);
		int f;
		f = (SCLK_MHZ * (int'(m) + 1)) >> rs;
		if (f < `GS_MIN_MHZ) f = `GS_MIN_MHZ;
		if (f > `GS_MAX_MHZ) f = `GS_MAX_MHZ;
		return 8'(f); // [RL1]
	endfunction

	function automatic logic [9:0] tsw_clks(input logic [3:0] code);
		if (code == 4'h0) return 10'(`LSWT_BASE_CLKS); // [RL8]
		return 10'(`LSWT_STEP_CLKS * (int'(code) + 1)); // [RL8]
	endfunction

	function automatic logic [9:0] gap_len(input logic [3:0] code, input phase_type ph);
		logic [9:0] t;
		logic [9:0] q;
		t = tsw_clks(code);
		q = t >> 2;
		// T3 takes the remainder so the four intervals always sum exactly
		if (ph == GAP_T3) return t - 10'(3) * q; // [RL6] [RL7]
		return q;
	endfunction

	function automatic logic slot_hit(input ghost_slot_type sl, input logic [3:0] ln);
		return sl.used && (sl.line == ln);
	endfunction

	function automatic logic [47:0] ones_mask(input logic [15:0] m, input logic [4:0] b);
		logic [47:0] r;
		r = 48'h0;
		for (int i = 0; i < 16; i++) begin
			r[i]      = m[i] ? 1'b1 : 1'b0;
			r[i + 16] = 1'b0;
		end
		return r << b;
	endfunction

	unit_state_type s_q;
	unit_state_type s_d;

	logic        hot;
	logic        cool;
	logic        rlow;
	logic        rhigh;
	logic        init_s;
	logic        blank;
	logic [47:0] suppress;
	logic [47:0] open_valid;
	logic        seg_end;
	logic        apb_setup;
	logic        apb_write;
	logic [3:0]  next_line;
	logic        matched;
	logic        placed;

	assign hot    = s_q.sync2[0];
	assign cool   = s_q.sync2[1];
	assign rlow   = s_q.sync2[2];
	assign rhigh  = s_q.sync2[3];
	assign init_s = s_q.sync2[4];

	assign pready               = 1'b1;
	assign prdata               = s_q.rdata;
	assign pslverr              = s_q.slverr;
	assign clock_range_select   = s_q.range_sel;
	assign clock_multiply_factor = s_q.mult;
	assign red_open_threshold   = s_q.thr_red;
	assign green_open_threshold = s_q.thr_green;
	assign blue_open_threshold  = s_q.thr_blue;
	assign channel_output       = s_q.chan_on;
	assign line_enable          = s_q.line_on;
	assign pre_discharge        = s_q.pre_dis;
	assign pwm_window           = s_q.pwm_on;
	assign half_divider_select  = s_q.half_div; // [RL2] [RL3]

	// ********************************
	// next state
	// ********************************
	always_comb begin
		s_d = s_q;
		apb_setup = psel && !penable;
		apb_write = psel && penable && pwrite;
		next_line = (32'(s_q.line) == LINES - 1) ? 4'h0 : s_q.line + 4'h1;
		seg_end   = 1'b0;
		matched   = 1'b0;
		placed    = 1'b0;

		// synchronisers: first stage feeds only the second
		s_d.sync1 = {init_request, ref_pin_high, ref_pin_low, temp_below_cool, temp_above_hot};
		s_d.sync2 = s_q.sync1;
		s_d.cmp1  = open_load_detect;
		s_d.cmp2  = s_q.cmp1;

		// hysteresis: enter on the hot or low side, leave only on the opposite comparator
		if (hot) begin
			s_d.hot_off = 1'b1; // [RL9]
		end else if (cool) begin
			s_d.hot_off = 1'b0; // [RL9]
		end
		if (rlow) begin
			s_d.ref_off = 1'b1; // [RL10]
		end else if (rhigh) begin
			s_d.ref_off = 1'b0; // [RL10]
		end

		// comparator results lag the pins by the synchroniser, so the drive state is
		// delayed to match; a channel just switched on still shows its off-state float
		s_d.on_seen1 = s_q.chan_on;
		s_d.on_seen2 = s_q.on_seen1;
		open_valid   = s_q.cmp2 & s_q.on_seen2 & s_q.chan_on; // [RL11] [RL12]

		// ********************************
		// scan sequence
		// ********************************
		s_d.count = s_q.count + 10'h1;
		case (s_q.phase)
			PWM_RUN: begin
				s_d.seg_open = s_q.seg_open | open_valid; // [RL13]
				if (32'(s_q.count) >= SEG_PWM_CLKS - 1) begin
					s_d.phase = GAP_T0; // [RL4]
					s_d.count = 10'h0;
					seg_end   = 1'b1;
				end
			end
			GAP_T0: begin
				if (s_q.count + 10'h1 >= gap_len(s_q.lswt, GAP_T0)) begin
					s_d.phase   = GAP_T1; // [RL4]
					s_d.count   = 10'h0;
					s_d.pre_dis = 1'b1;
				end
			end
			GAP_T1: begin
				if (s_q.count + 10'h1 >= gap_len(s_q.lswt, GAP_T1)) begin
					s_d.phase   = GAP_T2; // [RL5]
					s_d.count   = 10'h0;
					s_d.line_on = 16'h0;
				end
			end
			GAP_T2: begin
				if (s_q.count + 10'h1 >= gap_len(s_q.lswt, GAP_T2)) begin
					s_d.phase   = GAP_T3; // [RL6]
					s_d.count   = 10'h0;
					s_d.line    = next_line;
					s_d.line_on = 16'h1 << next_line;
				end
			end
			GAP_T3: begin
				if (s_q.count + 10'h1 >= gap_len(s_q.lswt, GAP_T3)) begin
					s_d.phase   = PWM_RUN; // [RL6]
					s_d.count   = 10'h0;
					s_d.pre_dis = 1'b0;
				end
			end
			default: begin
				s_d.phase = PWM_RUN;
				s_d.count = 10'h0;
			end
		endcase

		// ********************************
		// segment end: latch open data, record line, fill ghost slots
		// ********************************
		if (seg_end) begin
			s_d.open_data = s_q.seg_open | open_valid; // [RL13]
			s_d.seg_open  = 48'h0;
			if ((s_q.seg_open | open_valid) != 48'h0) begin
				s_d.line_record[s_q.line] = 1'b1; // [RL13]
				if (s_q.ghost_en) begin
					for (int i = 0; i < `GHOST_SLOTS; i++) begin
						if (slot_hit(s_q.slots[i], s_q.line)) begin
							s_d.slots[i].mask = s_q.slots[i].mask | s_q.seg_open | open_valid; // [RL20]
							matched = 1'b1;
						end
					end
					// a fourth faulty line finds no free slot and stays unsuppressed
					for (int i = 0; i < `GHOST_SLOTS; i++) begin
						if (!matched && !placed && !s_q.slots[i].used) begin
							s_d.slots[i].used = 1'b1; // [RL18]
							s_d.slots[i].line = s_q.line; // [RL20]
							s_d.slots[i].mask = s_q.seg_open | open_valid; // [RL20]
							placed = 1'b1;
						end
					end
				end
			end
		end
		if (!s_q.ghost_en) begin
			s_d.slots = '0; // [RL17]
		end

		// ********************************
		// channel drive
		// ********************************
		suppress = 48'h0;
		for (int i = 0; i < `GHOST_SLOTS; i++) begin
			if (s_q.ghost_en && slot_hit(s_q.slots[i], s_d.line)) begin
				suppress = suppress | s_q.slots[i].mask; // [RL16]
			end
		end
		blank = s_q.hot_off || s_q.ref_off; // [RL9] [RL10]
		s_d.chan_on = (s_d.phase == PWM_RUN && !blank) ? ~suppress : 48'h0; // [RL16]

		// ********************************
		// register bus
		// ********************************
		if (apb_setup) begin
			s_d.slverr = 1'b0;
			s_d.rdata  = 32'h0;
			case (paddr)
				`OFF_CONTROL: s_d.rdata = {8'h0, s_q.thr_blue, s_q.thr_green, s_q.thr_red,
					s_q.ghost_en, s_q.readback_en, s_q.lswt, s_q.mult, s_q.range_sel};
				`OFF_STATUS: s_d.rdata = {16'h0, gs_mhz(s_q.range_sel, s_q.mult),
					s_q.line, half_divider_select, s_q.ref_off, s_q.hot_off, 1'b0};
				`OFF_LINE_RECORD: s_d.rdata = {16'h0, s_q.line_record};
				// open data only shows once software has enabled readback
				`OFF_OPEN_LOW: s_d.rdata = s_q.readback_en ? s_q.open_data[31:0] : 32'h0;
				`OFF_OPEN_HIGH: s_d.rdata = s_q.readback_en ? {16'h0, s_q.open_data[47:32]} : 32'h0;
				`OFF_GHOST_LINES: s_d.rdata = {17'h0, s_q.slots[2].used, s_q.slots[2].line,
					s_q.slots[1].used, s_q.slots[1].line, s_q.slots[0].used, s_q.slots[0].line};
				default: s_d.slverr = 1'b1;
			endcase
		end
		if (apb_write && paddr == `OFF_CONTROL) begin
			s_d.range_sel   = pwdata[`CTL_RANGE_LSB +: 2]; // [RL1]
			s_d.mult        = pwdata[`CTL_MULT_LSB +: 4]; // [RL1]
			s_d.lswt        = pwdata[`CTL_LSWT_LSB +: 4]; // [RL7]
			s_d.readback_en = pwdata[`CTL_READBACK_BIT];
			s_d.ghost_en    = pwdata[`CTL_GHOST_BIT];
			s_d.thr_red     = pwdata[`CTL_RED_LSB +: 4]; // [RL11]
			s_d.thr_green   = pwdata[`CTL_GREEN_LSB +: 4]; // [RL11]
			s_d.thr_blue    = pwdata[`CTL_BLUE_LSB +: 4]; // [RL11]
		end

		// initialization wins over a write in the same cycle
		if (init_s) begin
			s_d.range_sel   = `RST_RANGE; // [RL19]
			s_d.mult        = `RST_MULT;
			s_d.lswt        = `RST_LSWT;
			s_d.readback_en = 1'b0;
			s_d.ghost_en    = 1'b0;
			s_d.thr_red     = `RST_THRESH;
			s_d.thr_green   = `RST_THRESH;
			s_d.thr_blue    = `RST_THRESH;
			s_d.slots       = '0; // [RL20]
			s_d.line_record = 16'h0;
		end

		// data outputs leave from flip-flops: decode the next state here
		s_d.pwm_on   = (s_d.phase == PWM_RUN);
		s_d.half_div = (gs_mhz(s_d.range_sel, s_d.mult) <= 8'(`GS_HALF_LIMIT_MHZ)); // [RL2] [RL3]
	end

	// ********************************
	// state register
	// ********************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q           <= '0;
			s_q.range_sel <= `RST_RANGE;
			s_q.mult      <= `RST_MULT;
			s_q.lswt      <= `RST_LSWT;
			s_q.thr_red   <= `RST_THRESH;
			s_q.thr_green <= `RST_THRESH;
			s_q.thr_blue  <= `RST_THRESH;
			s_q.phase     <= PWM_RUN;
			s_q.line_on   <= 16'h0001;
			s_q.slots     <= '0; // [RL20]
			s_q.pwm_on    <= 1'b1;
			s_q.half_div  <= RST_HALF;
		end else begin
			s_q <= s_d;
		end
	end
endmodule

// >>> dv/scan_timing_sva.sv
// assertion checker on the scan timing unit ports
`timescale 1ns/1ps
module scan_timing_sva #(
	parameter int SCLK_MHZ = 20
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        temp_above_hot,
	input wire logic        ref_pin_low,
	input wire logic        init_request,
	input wire logic [1:0]  clock_range_select,
	input wire logic [3:0]  clock_multiply_factor,
	input wire logic        half_divider_select,
	input wire logic [3:0]  red_open_threshold,
	input wire logic [47:0] channel_output,
	input wire logic [15:0] line_enable,
	input wire logic        pre_discharge,
	input wire logic        pwm_window
);
	// ****
	// cycles outside pwm; t0 length held once pre-discharge starts
	// ****
	logic [9:0] cnt_q;
	logic [9:0] t0_q;
	int         mhz;
	assign mhz = (SCLK_MHZ * (int'(clock_multiply_factor) + 1)) >> clock_range_select;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 10'h000;
			t0_q <= 10'h000;
		end else begin
			cnt_q <= pwm_window ? 10'h000 : cnt_q + 10'h001;
			t0_q <= pre_discharge ? t0_q : cnt_q + 10'h001;
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	half_div_a:
		assert property (half_divider_select == (mhz <= 80)) else $error("half divider wrong");
	hot_blank_a:
		assert property (temp_above_hot [*5] |-> channel_output == 48'h0) else $error("on while hot");
	ref_blank_a:
		assert property (ref_pin_low [*5] |-> channel_output == 48'h0) else $error("on, ref low");
	t0_quiet_a:
		assert property ($fell(pwm_window) |-> (!pre_discharge && line_enable != 16'h0000) [*8])
			else $error("t0 cut short");
	line_off_a:
		assert property ($fell(|line_enable) |-> pre_discharge && cnt_q == 10'h002 * t0_q)
			else $error("line off at wrong time");
	line_on_a:
		assert property ($rose(|line_enable) |-> !pwm_window && cnt_q == 10'h003 * t0_q)
			else $error("line on at wrong time");
	pwm_back_a:
		assert property ($rose(pwm_window) |-> cnt_q >= 10'h004 * t0_q && cnt_q <= 10'h004 * t0_q + 10'h003)
			else $error("t3 length wrong");
	init_cfg_a:
		assert property (init_request [*6] |-> clock_multiply_factor == 4'h3 && red_open_threshold == 4'h8)
			else $error("config kept in init");
	cover property ($rose(pre_discharge));
	cover property (temp_above_hot [*5]);
	cover property (ref_pin_low [*5]);
endmodule

bind scan_timing_open_fault_unit scan_timing_sva #(.SCLK_MHZ(SCLK_MHZ)) u_scan_timing_sva (
	.pclk(pclk), .presetn(presetn), .temp_above_hot(temp_above_hot), .ref_pin_low(ref_pin_low),
	.init_request(init_request), .clock_range_select(clock_range_select),
	.clock_multiply_factor(clock_multiply_factor), .half_divider_select(half_divider_select),
	.red_open_threshold(red_open_threshold), .channel_output(channel_output),
	.line_enable(line_enable), .pre_discharge(pre_discharge), .pwm_window(pwm_window)
);

// >>> dv/open_led_model.sv
// led matrix far side: per channel open comparators
`timescale 1ns/1ps
module open_led_model (
	input  wire logic [47:0] channel_output,
	input  wire logic [15:0] line_enable,
	input  wire logic        fault_on,
	output logic      [47:0] open_load_detect
);
	// ****
	// open leds: channel 5 on line 2, channel 40 on lines 3 to 5
	// ****
	always_comb begin
		open_load_detect = 48'h0;
		open_load_detect[5] = fault_on && line_enable[2];
		open_load_detect[40] = fault_on && (|line_enable[5:3]);
		// an undriven output floats high, so its comparator reads open
		open_load_detect = open_load_detect | ~channel_output;
	end
endmodule

// >>> dv/scan_timing_open_fault_unit_tb.sv
// self-checking bench: registers, protections, open detection and removal
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
	$display("MISMATCH %s exp %h got %h", n, e, g); end end
module scan_timing_open_fault_unit_tb;
	import scan_timing_pkg::*;
	localparam logic [31:0] base_word = 32'h0088800C;
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic temp_above_hot = 1'h0, temp_below_cool = 1'h0, ref_pin_low = 1'h0, ref_pin_high = 1'h0;
	logic init_request = 1'h0, fault_on = 1'h0, pready, pslverr, half_divider_select, err;
	logic pre_discharge, pwm_window;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [47:0] open_load_detect, channel_output;
	logic [15:0] line_enable;
	logic [3:0] clock_multiply_factor, red_open_threshold, green_open_threshold, blue_open_threshold;
	logic [1:0] clock_range_select;
	int mismatches = 0, n_compared = 0, cyc = 0, n, mhz;
	int rr[6] = '{0, 0, 0, 0, 1, 1};
	int mm[6] = '{3, 4, 15, 0, 7, 8};
	int codes[3] = '{0, 1, 15};
	scan_timing_open_fault_unit #(.SCLK_MHZ(20), .SEG_PWM_CLKS(16)) u_scan_timing_open_fault_unit (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.temp_above_hot(temp_above_hot), .temp_below_cool(temp_below_cool),
		.ref_pin_low(ref_pin_low), .ref_pin_high(ref_pin_high), .init_request(init_request),
		.open_load_detect(open_load_detect), .clock_range_select(clock_range_select),
		.clock_multiply_factor(clock_multiply_factor), .half_divider_select(half_divider_select),
		.red_open_threshold(red_open_threshold), .green_open_threshold(green_open_threshold),
		.blue_open_threshold(blue_open_threshold), .channel_output(channel_output),
		.line_enable(line_enable), .pre_discharge(pre_discharge), .pwm_window(pwm_window));
	open_led_model u_open_led_model (.channel_output(channel_output), .line_enable(line_enable),
		.fault_on(fault_on), .open_load_detect(open_load_detect));
	always #2.5 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 40000) begin
			mismatches++;
			end_sim();
		end
	end
	// ****
	// apb master and wait helpers
	// ****
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		@(posedge pclk);
		while (pready !== 1'h1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic chk_rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
		apb(1'h0, a, 32'h0);
		`CHK("prdata", e, rd & m)
	endtask
	task automatic until_pwm(input logic l);
		while (pwm_window !== l) @(posedge pclk);
	endtask
	// control writes land inside pwm so a transition never sees a half-changed code
	task automatic ctl(input logic [31:0] d);
		until_pwm(1'h0);
		until_pwm(1'h1);
		apb(1'h1, 12'h000, d);
	endtask
	task automatic seg_mid();
		until_pwm(1'h0);
		until_pwm(1'h1);
		repeat (3) @(posedge pclk);
	endtask
	task automatic at_line(input logic [15:0] l);
		while (line_enable !== l || pwm_window !== 1'h1) @(posedge pclk);
		repeat (3) @(posedge pclk);
	endtask
	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'h1;
		chk_rd(12'h000, base_word, 32'hFFFFFFFF);
		chk_rd(12'h008, 32'h0, 32'hFFFF);
		chk_rd(12'h014, 32'h0, 32'h7FFF);
		apb(1'h0, 12'h018, 32'h0);
		`CHK("pslverr", 1'h1, err)
		$display("reset test done");
		for (int i = 0; i < 6; i++) begin
			mhz = (20 * (mm[i] + 1)) >> rr[i];
			mhz = mhz < 40 ? 40 : (mhz > 160 ? 160 : mhz);
			ctl(32'h00888000 | 32'(mm[i] << 2) | 32'(rr[i]));
			chk_rd(12'h004, 32'(mhz << 8) | (mhz <= 80 ? 32'h8 : 32'h0), 32'hFF08);
			`CHK("half", 1'(mhz <= 80), half_divider_select)
			`CHK("range", ({2'(rr[i]), 4'(mm[i])}), ({clock_range_select, clock_multiply_factor}))
		end
		$display("clock test done");
		foreach (codes[i]) begin
			ctl(base_word | 32'(codes[i] << 6));
			until_pwm(1'h0);
			for (n = 0; pwm_window !== 1'h1; n++) @(posedge pclk);
			`CHK("gap", codes[i] == 0 ? 45 : 30 * (codes[i] + 1), n)
		end
		ctl(base_word);
		$display("line switch test done");
		for (int i = 0; i < 2; i++) begin
			{ref_pin_low, temp_above_hot} <= 2'(1 << i);
			repeat (8) @(posedge pclk);
			`CHK("blank", 48'h0, channel_output)
			chk_rd(12'h004, 32'(2 << i), 32'h6);
			{ref_pin_low, temp_above_hot} <= 2'h0;
			seg_mid();
			`CHK("held", 48'h0, channel_output)
			{ref_pin_high, temp_below_cool} <= 2'(1 << i);
			seg_mid();
			`CHK("resume", {48{1'h1}}, channel_output)
			{ref_pin_high, temp_below_cool} <= 2'h0;
		end
		$display("protection test done");
		ctl(32'h00777C10);
		seg_mid();
		`CHK("thr", 12'h777, ({blue_open_threshold, green_open_threshold, red_open_threshold}))
		init_request <= 1'h1;
		repeat (6) @(posedge pclk);
		init_request <= 1'h0;
		repeat (6) @(posedge pclk);
		chk_rd(12'h000, base_word, 32'hFFFFFFFF);
		`CHK("thr", 12'h888, ({blue_open_threshold, green_open_threshold, red_open_threshold}))
		ctl(base_word | 32'hC00);
		at_line(16'h0001);
		fault_on <= 1'h1;
		repeat (2100) @(posedge pclk);
		chk_rd(12'h008, 32'h3C, 32'hFFFF);
		chk_rd(12'h014, 32'h5272, 32'h7FFF);
		at_line(16'h0004);
		`CHK("ch5", 2'h2, channel_output[6:5])
		at_line(16'h0010);
		`CHK("ch40", 1'h0, channel_output[40])
		at_line(16'h0020);
		`CHK("ch40", 1'h1, channel_output[40])
		ctl(base_word | 32'h800);
		chk_rd(12'h00C, 32'h0, 32'hFFFFFFFF);
		ctl(base_word | 32'hC00);
		at_line(16'h0040);
		chk_rd(12'h010, 32'h100, 32'hFFFF);
		ctl(base_word | 32'h400);
		chk_rd(12'h014, 32'h0, 32'h7FFF);
		at_line(16'h0004);
		`CHK("ch5", 1'h1, channel_output[5])
		$display("open fault test done");
		end_sim();
	end
endmodule
